// ### src/atm_tx_gen_pkg.sv
package atm_tx_gen_pkg;

    // Number of transmit FIFO ports served by the generator.
    localparam int NUM_PORTS = 4;

    // Register indices; the byte address is four times the index.
    localparam logic [4:0] IDX_ERRPAT = 5'h03;
    localparam logic [4:0] IDX_GEN0 = 5'h04;
    localparam logic [4:0] IDX_RATE23 = 5'h08;
    localparam logic [4:0] IDX_RATE01 = 5'h09;
    localparam logic [4:0] IDX_IDLE12 = 5'h0A;
    localparam logic [4:0] IDX_IDLE34 = 5'h0B;
    localparam logic [4:0] IDX_HDR0 = 5'h0C;
    localparam logic [4:0] IDX_LAST = 5'h13;

    // Bit positions inside a port generation control register.
    localparam int GEN_INHIBIT_BIT = 13;
    localparam int GEN_ERR_CRC_BIT = 12;
    localparam int GEN_ERR_HEC_BIT = 11;
    localparam int GEN_DIS_CRC_BIT = 10;
    localparam int GEN_DIS_HEC_BIT = 9;
    localparam int GEN_INS_CLP_BIT = 8;
    localparam int GEN_INS_PT_BIT = 7;
    localparam int GEN_INS_VCI_BIT = 6;
    localparam int GEN_INS_VPI_BIT = 5;
    localparam int GEN_INS_GFC_BIT = 4;
    localparam int GEN_PRIO_LSB = 2;
    localparam int GEN_FMT_LSB = 0;
    localparam logic [15:0] GEN_WMASK = 16'h3FFF;

    // Values after reset.
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [7:0] REG8_RESET = 8'h00;

    // Header field layout over octets one to four.
    localparam logic [31:0] GFC_MASK = 32'hF0000000;
    localparam logic [31:0] VPI_MASK = 32'h0FF00000;
    localparam logic [31:0] VCI_MASK = 32'h000FFFF0;
    localparam logic [31:0] PT_MASK = 32'h0000000E;
    localparam logic [31:0] CLP_MASK = 32'h00000001;

    // Rate credit, HEC and CRC constants.
    localparam logic [8:0] RATE_FULL = 9'h0FF;
    localparam logic [7:0] HEC_POLY = 8'h07;
    localparam logic [7:0] HEC_COSET = 8'h55;
    localparam logic [9:0] CRC_ERR_MASK = 10'h001;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Cell length codes.
    typedef enum logic [1:0] {
        FMT_48 = 2'h0,
        FMT_52 = 2'h1,
        FMT_53 = 2'h2,
        FMT_57 = 2'h3
    } cell_fmt_e;

    // CRC-8 header check over octets one to four, plus the coset.
    function automatic logic [7:0] hec_calc(input logic [31:0] hdr);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            fb = c[7] ^ hdr[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ HEC_POLY;
            end
        end
        return c ^ HEC_COSET;
    endfunction

endpackage

// ### src/atm_tx_cell_gen.sv
// Operation
// R01 - Inhibit bit sends one idle cell instead
// R02 - Payload CRC error bit errors one cell, clears
// R03 - HEC error bit errors one cell, clears
// R04 - CRC disable passes FIFO CRC-10 field
// R05 - HEC disable passes FIFO octet five
// R06 - HEC error bits are mask XOR HEC
// R07 - GFC insert overwrites GFC in longer formats
// R08 - 48-octet format always takes programmed GFC
// R09 - VPI insert overwrites VPI field
// R10 - VCI insert overwrites VCI field
// R11 - PT insert overwrites PT field
// R12 - CLP insert overwrites CLP bit
// R13 - Two-bit priority chooses among ports
// R14 - Format code selects 48/52/53/57 octets
// R15 - Port 0 controls govern single-port mode
// R16 - Eight-bit rate per port, paired registers
// R17 - Zero rate sends no cells
// R18 - All-ones rate allows maximum rate
// R19 - Idle octets one, two from first register
// R20 - Idle octets three, four from second register
// R21 - Software programs idle header 00,00,00,01
// R22 - Software writes zero to reserved bits
// R23 - HEC mask is low byte of error pattern
// R24 - No eligible port means idle cell
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module atm_tx_cell_gen
    import atm_tx_gen_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic utopia_mode,
    input wire logic cell_slot,
    input wire logic [NUM_PORTS-1:0] port_valid,
    input wire logic [NUM_PORTS-1:0][31:0] port_header,
    input wire logic [NUM_PORTS-1:0][7:0] port_hec,
    input wire logic [NUM_PORTS-1:0][9:0] port_crc,
    input wire logic [NUM_PORTS-1:0][9:0] port_crc_calc,
    output logic [NUM_PORTS-1:0] port_take,
    output logic cell_valid,
    output logic cell_idle,
    output logic [1:0] cell_port,
    output logic [1:0] cell_format,
    output logic [31:0] cell_header,
    output logic [7:0] cell_hec,
    output logic [9:0] cell_crc
);

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [15:0] w_data_ff;
    logic [1:0] w_strb_ff;
    logic [NUM_PORTS-1:0][15:0] gen_ctrl_ff;
    logic [NUM_PORTS-1:0][7:0] rate_ff;
    logic [NUM_PORTS-1:0][7:0] acc_ff;
    logic [2*NUM_PORTS-1:0][15:0] hdr_ff;
    logic [15:0] idle12_ff, idle34_ff;
    logic [7:0] errpat_ff;
    logic [NUM_PORTS-1:0] port_take_ff;
    logic cell_valid_ff, cell_idle_ff;
    logic [1:0] cell_port_ff, cell_format_ff;
    logic [31:0] cell_header_ff;
    logic [7:0] cell_hec_ff;
    logic [9:0] cell_crc_ff;

    logic wr_go, wr_ok;
    logic [4:0] wr_idx, rd_idx;
    logic [NUM_PORTS-1:0] wr_gen;
    logic [NUM_PORTS-1:0][8:0] sum;
    logic [NUM_PORTS-1:0] elig;
    logic found, inh_sel, sent;
    logic [1:0] win, best;
    logic [15:0] sel_ctrl;
    logic [31:0] hv, hmask, hdr_sel, idle_hdr;
    logic [7:0] hec_sel;
    logic [9:0] crc_sel;

    // True when an address falls on a mapped register word.
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [4:0] idx;
        idx = a[6:2];
        return ((a >> 7) == '0) && (idx >= IDX_ERRPAT) && (idx <= IDX_LAST);
    endfunction

    // Merges a write into a 16-bit register under the two low strobes.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0] strb);
        return {strb[1] ? nw[15:8] : old[15:8],
                strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // Read multiplexer; narrow registers sit in the low bits.
    function automatic logic [15:0] read_reg(input logic [4:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == IDX_ERRPAT) begin
            v = {8'h00, errpat_ff};
        end else if (idx >= IDX_GEN0 && idx < IDX_RATE23) begin
            v = gen_ctrl_ff[2'(idx - IDX_GEN0)];
        end else if (idx == IDX_RATE23) begin
            v = {rate_ff[3], rate_ff[2]};
        end else if (idx == IDX_RATE01) begin
            v = {rate_ff[1], rate_ff[0]};
        end else if (idx == IDX_IDLE12) begin
            v = idle12_ff;
        end else if (idx == IDX_IDLE34) begin
            v = idle34_ff;
        end else if (idx >= IDX_HDR0 && idx <= IDX_LAST) begin
            v = hdr_ff[3'(idx - IDX_HDR0)];
        end
        return v;
    endfunction

    // Header fields to overwrite from the programmed value.
    function automatic logic [31:0] ins_mask(input logic [15:0] c);
        logic [31:0] m;
        m = 32'h00000000;
        if (c[GEN_INS_GFC_BIT] ||
            c[GEN_FMT_LSB +: 2] == FMT_48) begin
            m = m | GFC_MASK; // R07 R08
        end
        if (c[GEN_INS_VPI_BIT]) begin
            m = m | VPI_MASK; // R09
        end
        if (c[GEN_INS_VCI_BIT]) begin
            m = m | VCI_MASK; // R10
        end
        if (c[GEN_INS_PT_BIT]) begin
            m = m | PT_MASK; // R11
        end
        if (c[GEN_INS_CLP_BIT]) begin
            m = m | CLP_MASK; // R12
        end
        return m;
    endfunction

    // A write is performed once both address and data are held.
    assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_ok = addr_ok(aw_addr_ff);
    assign wr_idx = aw_addr_ff[6:2];
    assign rd_idx = araddr[6:2];

    // Write address and data channels, taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_addr_ff <= '0;
            w_data_ff <= REG16_RESET;
            w_strb_ff <= 2'h0;
        end else begin
            if (awvalid && awready_ff) begin
                aw_addr_ff <= awaddr;
                awready_ff <= 1'b0;
            end else if (bvalid_ff && bready) begin
                awready_ff <= 1'b1;
            end
            if (wvalid && wready_ff) begin
                w_data_ff <= wdata[15:0];
                w_strb_ff <= wstrb[1:0];
                wready_ff <= 1'b0;
            end else if (bvalid_ff && bready) begin
                wready_ff <= 1'b1;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {16'h0000, read_reg(rd_idx)};
            rresp_ff <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Plain registers: error pattern, rates, idle and port headers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            errpat_ff <= REG8_RESET;
            rate_ff <= '0;
            idle12_ff <= REG16_RESET;
            idle34_ff <= REG16_RESET;
            hdr_ff <= '0;
        end else if (wr_go && wr_ok) begin
            if (wr_idx == IDX_ERRPAT && w_strb_ff[0]) begin
                errpat_ff <= w_data_ff[7:0]; // R23
            end
            if (wr_idx == IDX_RATE23) begin
                {rate_ff[3], rate_ff[2]} <=
                    merge16({rate_ff[3], rate_ff[2]}, w_data_ff,
                            w_strb_ff); // R16
            end
            if (wr_idx == IDX_RATE01) begin
                {rate_ff[1], rate_ff[0]} <=
                    merge16({rate_ff[1], rate_ff[0]}, w_data_ff,
                            w_strb_ff); // R16
            end
            if (wr_idx == IDX_IDLE12) begin
                idle12_ff <= merge16(idle12_ff, w_data_ff, w_strb_ff);
            end
            if (wr_idx == IDX_IDLE34) begin
                idle34_ff <= merge16(idle34_ff, w_data_ff, w_strb_ff);
            end
            for (int k = 0; k < 2 * NUM_PORTS; k++) begin
                if (wr_idx == 5'(IDX_HDR0 + k)) begin
                    hdr_ff[k] <= merge16(hdr_ff[k], w_data_ff, w_strb_ff);
                end
            end
        end
    end

    // Write strobes for the four generation control registers.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr_gen[p] = wr_go && wr_ok && (wr_idx == 5'(IDX_GEN0 + p));
        end
    end

    // Generation control; a software write wins over a self-clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_ctrl_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_gen[p]) begin
                    gen_ctrl_ff[p] <= merge16(gen_ctrl_ff[p], w_data_ff,
                                              w_strb_ff) & GEN_WMASK;
                end else if (cell_slot && found && win == 2'(p)) begin
                    if (inh_sel) begin
                        gen_ctrl_ff[p][GEN_INHIBIT_BIT] <= 1'b0; // R01
                    end else begin
                        gen_ctrl_ff[p][GEN_ERR_CRC_BIT] <= 1'b0; // R02
                        gen_ctrl_ff[p][GEN_ERR_HEC_BIT] <= 1'b0; // R03
                    end
                end
            end
        end
    end

    // Rate credit and priority choice of the port for this slot.
    always_comb begin
        found = 1'b0;
        win = 2'h0;
        best = 2'h0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            sum[p] = {1'b0, acc_ff[p]} + {1'b0, rate_ff[p]};
            elig[p] = port_valid[p] && (rate_ff[p] != 8'h00) && // R17
                      (sum[p] >= RATE_FULL) && // R18
                      (!utopia_mode || p == 0); // R15
            if (elig[p] && (!found ||
                gen_ctrl_ff[p][GEN_PRIO_LSB +: 2] > best)) begin // R13
                found = 1'b1;
                win = 2'(p);
                best = gen_ctrl_ff[p][GEN_PRIO_LSB +: 2];
            end
        end
    end

    // Header, HEC and CRC of the chosen port's cell.
    assign sel_ctrl = gen_ctrl_ff[win];
    assign inh_sel = sel_ctrl[GEN_INHIBIT_BIT];
    assign sent = found && !inh_sel;
    assign hv = {hdr_ff[{win, 1'b0}], hdr_ff[{win, 1'b1}]};
    assign hmask = ins_mask(sel_ctrl);
    assign hdr_sel = (port_header[win] & ~hmask) | (hv & hmask);
    assign idle_hdr = {idle12_ff, idle34_ff}; // R19 R20

    // HEC is generated or passed, then errored by the pattern mask.
    always_comb begin
        hec_sel = sel_ctrl[GEN_DIS_HEC_BIT] ? port_hec[win] // R05
                                            : hec_calc(hdr_sel);
        if (sel_ctrl[GEN_ERR_HEC_BIT]) begin
            hec_sel = hec_sel ^ errpat_ff; // R03 R06 R23
        end
        crc_sel = sel_ctrl[GEN_DIS_CRC_BIT] ? port_crc[win] // R04
                                            : port_crc_calc[win];
        if (sel_ctrl[GEN_ERR_CRC_BIT]) begin
            crc_sel = crc_sel ^ CRC_ERR_MASK; // R02
        end
    end

    // Rate credit accumulators, spent when a cell is sent.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= '0;
        end else if (cell_slot) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (sent && win == 2'(p)) begin
                    acc_ff[p] <= 8'(sum[p] - RATE_FULL); // R16
                end else if (sum[p] > RATE_FULL) begin
                    acc_ff[p] <= RATE_FULL[7:0];
                end else begin
                    acc_ff[p] <= sum[p][7:0];
                end
            end
        end
    end

    // Cell output: one cell per slot, idle when nothing is sent.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_take_ff <= '0;
            cell_valid_ff <= 1'b0;
            cell_idle_ff <= 1'b0;
            cell_port_ff <= 2'h0;
            cell_format_ff <= FMT_48;
            cell_header_ff <= 32'h00000000;
            cell_hec_ff <= 8'h00;
            cell_crc_ff <= 10'h000;
        end else begin
            port_take_ff <= '0;
            cell_valid_ff <= cell_slot;
            if (cell_slot && sent) begin
                port_take_ff[win] <= 1'b1;
                cell_idle_ff <= 1'b0;
                cell_port_ff <= win;
                cell_format_ff <= sel_ctrl[GEN_FMT_LSB +: 2]; // R14
                cell_header_ff <= hdr_sel;
                cell_hec_ff <= hec_sel;
                cell_crc_ff <= crc_sel;
            end else if (cell_slot) begin
                cell_idle_ff <= 1'b1; // R01 R24
                cell_port_ff <= win;
                cell_format_ff <= gen_ctrl_ff[0][GEN_FMT_LSB +: 2];
                cell_header_ff <= idle_hdr; // R19 R20
                cell_hec_ff <= hec_calc(idle_hdr);
                cell_crc_ff <= 10'h000;
            end
        end
    end

    // Outputs straight from their flip-flops.
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign port_take = port_take_ff;
    assign cell_valid = cell_valid_ff;
    assign cell_idle = cell_idle_ff;
    assign cell_port = cell_port_ff;
    assign cell_format = cell_format_ff;
    assign cell_header = cell_header_ff;
    assign cell_hec = cell_hec_ff;
    assign cell_crc = cell_crc_ff;

    // Checks on the generator's own outputs.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence slot_sent_s;
        cell_slot && sent;
    endsequence

    sequence data_cell_s;
        cell_valid && !cell_idle;
    endsequence

    inhibit_idle_a: assert property ( // R01
        cell_slot && found && inh_sel |=> cell_valid && cell_idle &&
        port_take == '0)
        else $error("inhibited slot did not carry an idle cell");
    crc_err_once_a: assert property ( // R02
        slot_sent_s ##0 sel_ctrl[GEN_ERR_CRC_BIT] && !wr_gen[win] |=>
        data_cell_s ##0 !gen_ctrl_ff[cell_port][GEN_ERR_CRC_BIT])
        else $error("payload CRC error bit not cleared after one cell");
    hec_err_once_a: assert property ( // R03
        slot_sent_s ##0 sel_ctrl[GEN_ERR_HEC_BIT] && !wr_gen[win] |=>
        data_cell_s ##0 !gen_ctrl_ff[cell_port][GEN_ERR_HEC_BIT])
        else $error("HEC error bit not cleared after one cell");
    hec_pass_a: assert property ( // R05
        slot_sent_s ##0 sel_ctrl[GEN_DIS_HEC_BIT] &&
        !sel_ctrl[GEN_ERR_HEC_BIT] |=> cell_hec == $past(port_hec[win]))
        else $error("HEC octet not passed through");
    crc_pass_a: assert property ( // R04
        slot_sent_s ##0 sel_ctrl[GEN_DIS_CRC_BIT] &&
        !sel_ctrl[GEN_ERR_CRC_BIT] |=> cell_crc == $past(port_crc[win]))
        else $error("CRC-10 field not passed through");
    gfc_fmt48_a: assert property ( // R08
        slot_sent_s ##0 sel_ctrl[1:0] == FMT_48 |=>
        cell_header[31:28] == $past(hv[31:28]))
        else $error("48-octet cell did not take programmed GFC");
    rate_zero_a: assert property ( // R17
        port_take[0] |-> $past(rate_ff[0]) != 8'h00)
        else $error("port with zero rate sent a cell");
    rate_full_a: assert property ( // R18
        cell_slot && utopia_mode && port_valid[0] &&
        rate_ff[0] == 8'hFF && !gen_ctrl_ff[0][GEN_INHIBIT_BIT] |=>
        port_take[0])
        else $error("full-rate port was refused a slot");
    utopia_port0_a: assert property ( // R15
        cell_slot && utopia_mode |=> port_take[3:1] == 3'h0)
        else $error("single-port mode sent from another port");
    idle_header_a: assert property ( // R24
        cell_slot && !found |=> cell_idle &&
        cell_header == $past(idle_hdr))
        else $error("empty slot did not carry the idle header");

endmodule

// ### verification/atm_layer_model.sv
`timescale 1ns/1ps
module atm_layer_model
    import atm_tx_gen_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_PORTS-1:0] offer,
    input wire logic [NUM_PORTS-1:0] port_take,
    output logic [NUM_PORTS-1:0] port_valid,
    output logic [NUM_PORTS-1:0][31:0] port_header,
    output logic [NUM_PORTS-1:0][7:0] port_hec,
    output logic [NUM_PORTS-1:0][9:0] port_crc,
    output logic [NUM_PORTS-1:0][9:0] port_crc_calc
);
    logic [NUM_PORTS-1:0][7:0] seq_ff;

    // A fresh cell stands at a port from the edge after its take.
    always_ff @(posedge aclk) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (!aresetn) begin
                seq_ff[p] <= 8'h41 * 8'(p);
            end else if (port_take[p]) begin
                seq_ff[p] <= seq_ff[p] + 8'h3B;
            end
        end
    end

    // Each waiting cell is whole; its fields change from cell to cell.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_header[p] = {4{seq_ff[p]}} ^ 32'h9E3C5A7D;
            port_hec[p] = seq_ff[p] ^ 8'h96;
            port_crc[p] = {2'h1, seq_ff[p]};
            port_crc_calc[p] = {2'h2, ~seq_ff[p]};
        end
    end

    // The bench chooses which ports hold a cell.
    assign port_valid = offer;
endmodule

// ### verification/atm_tx_cell_generation_control_test.sv
`timescale 1ns/1ps
module atm_tx_cell_generation_control_test
    import atm_tx_gen_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic utopia_mode = 1'b0, cell_slot = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h3;
    logic [NUM_PORTS-1:0] offer = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cell_valid, cell_idle;
    logic [1:0] bresp, rresp, cell_port, cell_format;
    logic [31:0] rdata, cell_header;
    logic [NUM_PORTS-1:0] port_valid, port_take;
    logic [NUM_PORTS-1:0][31:0] port_header;
    logic [NUM_PORTS-1:0][7:0] port_hec;
    logic [NUM_PORTS-1:0][9:0] port_crc, port_crc_calc;
    logic [7:0] cell_hec;
    logic [9:0] cell_crc;
    int failures = 0, tests_run = 0;

    // The clock toggles every half period of 2.5 ns.
    always #2.5 aclk = ~aclk;

    atm_tx_cell_gen i_atm_tx_cell_gen (
        .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .utopia_mode, .cell_slot, .port_valid, .port_header, .port_hec,
        .port_crc, .port_crc_calc, .port_take, .cell_valid, .cell_idle,
        .cell_port, .cell_format, .cell_header, .cell_hec, .cell_crc
    );
    atm_layer_model i_atm_layer_model (
        .aclk, .aresetn, .offer, .port_take, .port_valid, .port_header,
        .port_hec, .port_crc, .port_crc_calc
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(r));
    endtask

    task automatic rck(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(r));
    endtask

    // One slot pulse; outputs are looked at once the edge has landed.
    task automatic slot();
        @(posedge aclk);
        cell_slot <= 1'b1;
        @(posedge aclk);
        cell_slot <= 1'b0;
        #1;
        chk(32'(cell_valid), 32'h1);
    endtask

    task automatic sent(input logic [1:0] p);
        chk(32'(cell_idle), 32'h0);
        chk(32'(cell_port), 32'(p));
        chk(32'(port_take), 32'(4'h1 << p));
    endtask

    task automatic t_reset();
        for (int i = 3; i < 20; i++) rck(8'(4 * i), 32'h0);
        rck(8'h80, 32'h0, RESP_SLVERR);
        rck(8'h08, 32'h0, RESP_SLVERR);
        wr(8'h8C, 16'h00FF, RESP_SLVERR);
        rck(8'h0C, 32'h0);
    endtask

    task automatic t_idle();
        wr(8'h28, 16'h1234);
        wr(8'h2C, 16'h5601);
        slot();
        chk(32'(cell_idle), 32'h1);
        chk(32'(port_take), 32'h0);
        chk(cell_header, 32'h12345601);
        wr(8'h28, 16'h0000);
        wr(8'h2C, 16'h0001);
        slot();
        chk(32'(cell_hec), 32'h52);
    endtask

    task automatic t_rate();
        wr(8'h24, 16'hFF00);
        offer <= 4'h3;
        rck(8'h24, 32'h0000FF00);
        slot();
        sent(2'h1);
        slot();
        sent(2'h1);
        wr(8'h24, 16'h00FF);
        slot();
        sent(2'h0);
        @(posedge aclk);
        offer <= 4'h2;
        slot();
        chk(32'(cell_idle), 32'h1);
    endtask

    task automatic t_prio();
        wr(8'h20, 16'hFFFF);
        wr(8'h24, 16'hFFFF);
        wr(8'h10, 16'h0004);
        wr(8'h18, 16'h000C);
        offer <= 4'h5;
        slot();
        sent(2'h2);
        wr(8'h10, 16'h000C);
        wr(8'h18, 16'h0000);
        slot();
        sent(2'h0);
        wr(8'h10, 16'h0000);
    endtask

    task automatic t_fmt();
        for (int f = 0; f < 4; f++) begin
            wr(8'h14, 16'(f));
            offer <= 4'h2;
            slot();
            chk(32'(cell_format), 32'(f));
        end
    endtask

    task automatic t_ins();
        logic [31:0] m [7] = '{32'h0, GFC_MASK, VPI_MASK, VCI_MASK,
                               PT_MASK, CLP_MASK, GFC_MASK};
        logic [15:0] c [7] = '{16'h0001, 16'h0011, 16'h0021, 16'h0041,
                               16'h0081, 16'h0101, 16'h0000};
        logic [31:0] h;
        wr(8'h38, 16'hABCD);
        wr(8'h3C, 16'hEF01);
        for (int i = 0; i < 7; i++) begin
            wr(8'h14, c[i]);
            slot();
            h = port_header[1];
            chk(cell_header, (h & ~m[i]) | (32'hABCDEF01 & m[i]));
        end
    endtask

    task automatic t_err();
        wr(8'h0C, 16'h00A5);
        wr(8'h14, 16'h1E01);
        slot();
        chk(32'(cell_hec), 32'(port_hec[1] ^ 8'hA5));
        chk(32'(cell_crc), 32'(port_crc[1] ^ CRC_ERR_MASK));
        rck(8'h14, 32'h00000601);
        slot();
        chk(32'(cell_hec), 32'(port_hec[1]));
        chk(32'(cell_crc), 32'(port_crc[1]));
        wr(8'h14, 16'h0001);
        slot();
        chk(32'(cell_crc), 32'(port_crc_calc[1]));
        wr(8'h38, 16'h0000);
        wr(8'h3C, 16'h0001);
        wr(8'h14, 16'h09F1);
        slot();
        chk(cell_header, 32'h00000001);
        chk(32'(cell_hec), 32'hF7);
    endtask

    task automatic t_inh();
        wr(8'h14, 16'h2001);
        slot();
        chk(32'(cell_idle), 32'h1);
        chk(32'(port_take), 32'h0);
        slot();
        sent(2'h1);
        rck(8'h14, 32'h00000001);
    endtask

    task automatic t_utop();
        wr(8'h10, 16'h0003);
        utopia_mode <= 1'b1;
        slot();
        chk(32'(cell_idle), 32'h1);
        @(posedge aclk);
        offer <= 4'h3;
        slot();
        sent(2'h0);
        chk(32'(cell_format), 32'h3);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_idle();
        t_rate();
        t_prio();
        t_fmt();
        t_ins();
        t_err();
        t_inh();
        t_utop();
        print_verdict();
    end

    // The whole run needs well under this many cycles.
    initial begin
        repeat (8000) @(posedge aclk);
        failures++;
        print_verdict();
    end
endmodule
